// [hdl/tbpc_pkg.sv]
// Purpose: shared constants of the bit error test pattern control block
// Assumes: 32-bit AXI4-Lite register bus, one-bit serial test streams
// Notes:   every offset, field position, reset value and run length lives here
package tbpc_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SWAP_OFS = 8'h04;

  // control/status field positions
  localparam int TYPE_BIT = 7;
  localparam int INJ_BIT  = 6;
  localparam int INV_BIT  = 5;
  localparam int LOCK_BIT = 4;
  localparam int DET_BIT  = 3;
  localparam int GEN_BIT  = 2;
  localparam int RXS_BIT  = 1;
  localparam int TXS_BIT  = 0;
  localparam int SWAP_BIT = 0;

  // reset values and writable mask (lock bit is read only)
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] CTRL_WMSK = 8'hEF;
  localparam logic       SWAP_RST  = 1'b0;

  // pattern selection
  localparam logic PAT_PRBS15 = 1'b0;
  localparam logic PAT_QRTS   = 1'b1;

  // pattern engine history and generator seed
  localparam int          HIST_W   = 20;
  localparam logic [19:0] GEN_SEED = 20'h00001;

  // detector run lengths, in received bits
  localparam logic [5:0] SEED_LEN   = 6'h14;
  localparam logic [5:0] LOCK_RUN   = 6'h20;
  localparam logic [5:0] UNLOCK_RUN = 6'h08;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [hdl/tbpc_strm_if.sv]
// Purpose: one-bit serial stream with valid/ready between block modules
// Assumes: a word moves on the rising edge where valid and ready are high
// Notes:   source holds data while valid is high and ready is low
`timescale 1ns/1ps
interface tbpc_strm_if;
  logic valid;
  logic ready;
  logic data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [hdl/tbpc_buf2.sv]
// Purpose: two-entry stream buffer so a stalled receiver loses no bit
// Assumes: synchronous active-low reset
// Notes:   full and empty are exact; output data comes from a flip-flop
`timescale 1ns/1ps
module tbpc_buf2 (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // filling side
  tbpc_strm_if.snk    in_s,
  // draining side
  tbpc_strm_if.src    out_s
);

  logic [1:0] cnt_r;
  logic       d0_r;
  logic       d1_r;
  logic       push;
  logic       pop;

  // handshakes; full refuses, empty offers nothing
  assign in_s.ready  = (cnt_r != 2'h2);
  assign out_s.valid = (cnt_r != 2'h0);
  assign out_s.data  = d0_r;
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  // occupancy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 2'h0;
    end else if (push & ~pop) begin
      cnt_r <= cnt_r + 2'h1;
    end else if (pop & ~push) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end

  // storage: d0 is the head, d1 the second entry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      d0_r <= 1'b0;
      d1_r <= 1'b0;
    end else begin
      if (pop) begin
        d0_r <= (cnt_r == 2'h2) ? d1_r : in_s.data;
      end else if (push && cnt_r == 2'h0) begin
        d0_r <= in_s.data;
      end
      if (push && ((cnt_r == 2'h1 && !pop) || (cnt_r == 2'h2 && pop))) begin
        d1_r <= in_s.data;
      end
    end
  end

endmodule

// [hdl/tbpc_top.sv]
// Purpose: bit error test pattern generator/detector control for one T1 channel
// Assumes: all streams are one bit per transfer, synchronous to SYS_CLK
// Notes:   registers over AXI4-Lite; both outputs pass a two-entry buffer
//
// Behaviour
// - type bit picks PRBS15 or quasi-random pattern
// - swap off: generator drives line transmit output
// - swap on: generator drives receive backplane output
// - inject rising edge flips exactly one bit
// - injection only acts while generation enabled
// - injected error follows generator output routing
// - invert bit inverts generated and checked data
// - lock status reads detector lock state
// - swap off: detector checks line receive data
// - swap on: detector checks transmit backplane data
// - generate enable turns generator on or off
// - receive bypass bit skips receive framing
// - transmit bypass bit skips transmit framing
`timescale 1ns/1ps
module tbpc_top (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  // AXI4-Lite write address
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output wire logic        AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output wire logic        WREADY,
  // AXI4-Lite write response
  output wire logic [1:0]  BRESP,
  output wire logic        BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read address
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output wire logic        ARREADY,
  // AXI4-Lite read data
  output wire logic [31:0] RDATA,
  output wire logic [1:0]  RRESP,
  output wire logic        RVALID,
  input  wire logic        RREADY,
  // transmit backplane input stream
  input  wire logic        TXB_DATA,
  input  wire logic        TXB_VALID,
  output wire logic        TXB_READY,
  // line receive input stream
  input  wire logic        LRX_DATA,
  input  wire logic        LRX_VALID,
  output wire logic        LRX_READY,
  // line transmit output stream
  output wire logic        LTX_DATA,
  output wire logic        LTX_VALID,
  input  wire logic        LTX_READY,
  // receive backplane output stream
  output wire logic        RXB_DATA,
  output wire logic        RXB_VALID,
  input  wire logic        RXB_READY,
  // framer controls and status
  output wire logic        RX_FRAMER_SKIP,
  output wire logic        TX_FRAMER_SKIP,
  output wire logic        PATTERN_LOCK
);

  // next pattern bit from a history whose bit 0 is the newest
  function automatic logic pat_next(input logic typ, input logic [19:0] h);
    logic b;
    b = 1'b0;
    if (typ == tbpc_pkg::PAT_PRBS15) begin
      b = h[14] ^ h[13];
    end else begin
      b = h[19] ^ h[16];
    end
    return b;
  endfunction

  // register state
  logic [7:0]  ctrl_r;
  logic        swap_r;
  logic        lock_r;

  // bus state
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        wstrb0_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        do_write;

  // pattern engine state
  logic [19:0] gen_hist_r;
  logic [19:0] det_hist_r;
  logic        inj_prev_r;
  logic        inj_pend_r;
  logic [5:0]  seed_cnt_r;
  logic [5:0]  run_r;

  // decoded controls
  logic        pat_type;
  logic        gen_en;
  logic        det_en;
  logic        inv_en;
  logic        gen_line;
  logic        gen_bp;
  logic        gen_bit;
  logic        gen_take;
  logic        mon_valid;
  logic        mon_data;
  logic        mon_take;
  logic        rx_bit;
  logic        exp_bit;
  logic        match;

  // buffer connections
  tbpc_strm_if ltx_in ();
  tbpc_strm_if ltx_out ();
  tbpc_strm_if rxb_in ();
  tbpc_strm_if rxb_out ();

  assign pat_type = ctrl_r[tbpc_pkg::TYPE_BIT];
  assign gen_en   = ctrl_r[tbpc_pkg::GEN_BIT];
  assign det_en   = ctrl_r[tbpc_pkg::DET_BIT];
  assign inv_en   = ctrl_r[tbpc_pkg::INV_BIT];

  // generator routing by swap setting
  assign gen_line = gen_en & ~swap_r;
  assign gen_bp   = gen_en & swap_r;

  // generated bit: pattern, optional inversion, pending single error
  assign gen_bit  = pat_next(pat_type, gen_hist_r) ^ inv_en ^ inj_pend_r;
  assign gen_take = (gen_line & ltx_in.ready) | (gen_bp & rxb_in.ready);

  // line transmit path: generator replaces backplane traffic while active
  assign ltx_in.valid = gen_line ? 1'b1 : TXB_VALID;
  assign ltx_in.data  = gen_line ? gen_bit : TXB_DATA;
  assign TXB_READY    = gen_line ? 1'b1 : ltx_in.ready;

  // receive backplane path: generator replaces line traffic while active
  assign rxb_in.valid = gen_bp ? 1'b1 : LRX_VALID;
  assign rxb_in.data  = gen_bp ? gen_bit : LRX_DATA;
  assign LRX_READY    = gen_bp ? 1'b1 : rxb_in.ready;

  // buffers in both output paths; receiver stalls back up to the inputs, or stop only the generator on the path it drives
  tbpc_buf2 u_ltx_buf (
    .clk   (SYS_CLK),
    .rst_n (NRST),
    .in_s  (ltx_in),
    .out_s (ltx_out)
  );

  tbpc_buf2 u_rxb_buf (
    .clk   (SYS_CLK),
    .rst_n (NRST),
    .in_s  (rxb_in),
    .out_s (rxb_out)
  );

  assign LTX_DATA      = ltx_out.data;
  assign LTX_VALID     = ltx_out.valid;
  assign ltx_out.ready = LTX_READY;
  assign RXB_DATA      = rxb_out.data;
  assign RXB_VALID     = rxb_out.valid;
  assign rxb_out.ready = RXB_READY;

  // detector input: line receive side, or transmit backplane when swapped
  assign mon_valid = swap_r ? TXB_VALID : LRX_VALID;
  assign mon_data  = swap_r ? TXB_DATA : LRX_DATA;
  assign mon_take  = det_en & mon_valid & (swap_r ? TXB_READY : LRX_READY);
  assign rx_bit    = mon_data ^ inv_en;
  assign exp_bit   = pat_next(pat_type, det_hist_r);
  assign match     = (rx_bit == exp_bit);

  // generator history advances only when a generated bit is taken
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      gen_hist_r <= tbpc_pkg::GEN_SEED;
    end else if (gen_take) begin
      gen_hist_r <= {gen_hist_r[18:0], pat_next(pat_type, gen_hist_r)};
    end
  end

  // error injection: a 0 to 1 change arms one flip, cleared once emitted;
  // arming wins over the clear so a back-to-back request is not lost
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      inj_prev_r <= 1'b0;
      inj_pend_r <= 1'b0;
    end else begin
      inj_prev_r <= ctrl_r[tbpc_pkg::INJ_BIT];
      if (gen_en && ctrl_r[tbpc_pkg::INJ_BIT] && !inj_prev_r) begin
        inj_pend_r <= 1'b1;
      end else if (!gen_en || gen_take) begin
        inj_pend_r <= 1'b0;
      end
    end
  end

  // detector history: self-synchronising, always filled from received bits
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      det_hist_r <= 20'h00000;
    end else if (mon_take) begin
      det_hist_r <= {det_hist_r[18:0], rx_bit};
    end
  end

  // detector seeding, lock and loss of lock
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !det_en) begin
      seed_cnt_r <= 6'h00;
      run_r      <= 6'h00;
      lock_r     <= 1'b0;
    end else if (mon_take) begin
      if (seed_cnt_r != tbpc_pkg::SEED_LEN) begin
        seed_cnt_r <= seed_cnt_r + 6'h01;
        run_r      <= 6'h00;
      end else if (!lock_r) begin
        if (!match) begin
          run_r <= 6'h00;
        end else if (run_r == tbpc_pkg::LOCK_RUN - 6'h01) begin
          run_r  <= 6'h00;
          lock_r <= 1'b1;
        end else begin
          run_r <= run_r + 6'h01;
        end
      end else begin
        if (match) begin
          run_r <= 6'h00;
        end else if (run_r == tbpc_pkg::UNLOCK_RUN - 6'h01) begin
          run_r      <= 6'h00;
          lock_r     <= 1'b0;
          seed_cnt_r <= 6'h00;                             // reseed after a slip
        end else begin
          run_r <= run_r + 6'h01;
        end
      end
    end
  end

  assign PATTERN_LOCK   = lock_r;
  assign RX_FRAMER_SKIP = ctrl_r[tbpc_pkg::RXS_BIT];
  assign TX_FRAMER_SKIP = ctrl_r[tbpc_pkg::TXS_BIT];

  // write channels: address and data latched independently, in any order
  assign AWREADY  = ~aw_got_r & ~bvalid_r;
  assign WREADY   = ~w_got_r & ~bvalid_r;
  assign do_write = aw_got_r & w_got_r & ~bvalid_r;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      aw_got_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (AWVALID && AWREADY) begin
      aw_got_r <= 1'b1;
      awaddr_r <= AWADDR;
    end else if (do_write) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      w_got_r  <= 1'b0;
      wdata_r  <= 32'h00000000;
      wstrb0_r <= 1'b0;
    end else if (WVALID && WREADY) begin
      w_got_r  <= 1'b1;
      wdata_r  <= WDATA;
      wstrb0_r <= WSTRB[0];
    end else if (do_write) begin
      w_got_r <= 1'b0;
    end
  end

  // register update; only byte lane 0 carries fields
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      ctrl_r <= tbpc_pkg::CTRL_RST;
      swap_r <= tbpc_pkg::SWAP_RST;
    end else if (do_write && wstrb0_r) begin
      if (awaddr_r[7:2] == tbpc_pkg::CTRL_OFS[7:2]) begin
        ctrl_r <= wdata_r[7:0] & tbpc_pkg::CTRL_WMSK;
      end else if (awaddr_r[7:2] == tbpc_pkg::SWAP_OFS[7:2]) begin
        swap_r <= wdata_r[tbpc_pkg::SWAP_BIT];
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      bvalid_r <= 1'b0;
      bresp_r  <= tbpc_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr_r[7:2] == tbpc_pkg::CTRL_OFS[7:2] ||
                   awaddr_r[7:2] == tbpc_pkg::SWAP_OFS[7:2]) ?
                  tbpc_pkg::RESP_OKAY : tbpc_pkg::RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  assign BVALID = bvalid_r;
  assign BRESP  = bresp_r;

  // read: data captured at the address handshake, lock bit taken from the detector state at that handshake
  assign ARREADY = ~rvalid_r;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= tbpc_pkg::RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_r <= 1'b1;
      rresp_r  <= tbpc_pkg::RESP_OKAY;
      if (ARADDR[7:2] == tbpc_pkg::CTRL_OFS[7:2]) begin
        rdata_r <= {24'h000000, ctrl_r[7:5], lock_r, ctrl_r[3:0]};
      end else if (ARADDR[7:2] == tbpc_pkg::SWAP_OFS[7:2]) begin
        rdata_r <= {31'h00000000, swap_r};
      end else begin
        rdata_r <= 32'h00000000;
        rresp_r <= tbpc_pkg::RESP_SLVERR;
      end
    end else if (RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  assign RVALID = rvalid_r;
  assign RDATA  = rdata_r;
  assign RRESP  = rresp_r;

endmodule

// [sim/tbpc_far.sv]
// Purpose: far-side loopback of one serial stream, line or backplane
// Assumes: bits move on valid and ready high at a rising edge
// Notes:   random stalls both ways; flip and mute are faults set by the bench
`timescale 1ns/1ps
module tbpc_far (
  // clock, reset and faults
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic flip,
  input  wire logic mute,
  // stream out of the block
  input  wire logic in_data,
  input  wire logic in_valid,
  output logic      in_ready = 1'b0,
  // stream back into the block
  output logic      out_data = 1'b0,
  output logic      out_valid = 1'b0,
  input  wire logic out_ready
);
  logic q[$];
  // taken bits return in order; an idle line toggles so no stale bit looks valid
  always @(posedge clk) begin
    if (!rst_n) begin
      q.delete();
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (in_valid && in_ready && !mute) q.push_back(in_data ^ flip);
      in_ready <= ($urandom % 4) != 0;
      if (!out_valid || out_ready) begin
        if (q.size() > 0 && ($urandom % 4) != 0) begin
          out_data <= q.pop_front();
          out_valid <= 1'b1;
        end else begin
          out_data <= ~out_data;
          out_valid <= 1'b0;
        end
      end
    end
  end
endmodule

// [sim/tbpc_sva.sv]
// Purpose: port timing checks of the test pattern block
// Assumes: one clock, synchronous active-low reset
// Notes:   lock needs 20 seed and 32 matching bits, so never before 52 cycles
`timescale 1ns/1ps
module tbpc_sva (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  // bus answers
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  // output streams
  input wire logic        LTX_DATA,
  input wire logic        LTX_VALID,
  input wire logic        LTX_READY,
  input wire logic        RXB_DATA,
  input wire logic        RXB_VALID,
  input wire logic        RXB_READY,
  // status
  input wire logic        RX_FRAMER_SKIP,
  input wire logic        TX_FRAMER_SKIP,
  input wire logic        PATTERN_LOCK
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  logic [5:0] since_r;
  // saturating cycles since reset
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      since_r <= 6'h00;
    end else if (since_r != 6'h3F) begin
      since_r <= since_r + 6'h01;
    end
  end
  property p_rst_clr; $rose(NRST) |-> !RX_FRAMER_SKIP && !TX_FRAMER_SKIP && !PATTERN_LOCK;
  endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("status not clear after reset");
  property p_b_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_hi; RVALID |-> RDATA[31:8] == 24'h0; endproperty
  a_r_hi: assert property (p_r_hi) else $error("upper read bits set");
  property p_ltx; LTX_VALID && !LTX_READY |=> LTX_VALID && $stable(LTX_DATA); endproperty
  a_ltx: assert property (p_ltx) else $error("line bit lost in stall");
  property p_rxb; RXB_VALID && !RXB_READY |=> RXB_VALID && $stable(RXB_DATA); endproperty
  a_rxb: assert property (p_rxb) else $error("backplane bit lost in stall");
  property p_txs; $changed(TX_FRAMER_SKIP) |-> $rose(BVALID); endproperty
  a_txs: assert property (p_txs) else $error("tx skip moved without write");
  property p_rxs; $changed(RX_FRAMER_SKIP) |-> $rose(BVALID); endproperty
  a_rxs: assert property (p_rxs) else $error("rx skip moved without write");
  property p_lock; $rose(PATTERN_LOCK) |-> since_r >= 6'h34; endproperty
  a_lock: assert property (p_lock) else $error("lock too early");
  c_slverr: cover property (BVALID && BREADY && BRESP == tbpc_pkg::RESP_SLVERR);
  c_lock: cover property ($rose(PATTERN_LOCK));
  c_unlock: cover property ($fell(PATTERN_LOCK));
  c_stall: cover property (LTX_VALID && !LTX_READY);
endmodule
bind tbpc_top tbpc_sva u_sva (.SYS_CLK(SYS_CLK), .NRST(NRST), .BVALID(BVALID),
  .BREADY(BREADY), .BRESP(BRESP), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
  .LTX_DATA(LTX_DATA), .LTX_VALID(LTX_VALID), .LTX_READY(LTX_READY),
  .RXB_DATA(RXB_DATA), .RXB_VALID(RXB_VALID), .RXB_READY(RXB_READY),
  .RX_FRAMER_SKIP(RX_FRAMER_SKIP), .TX_FRAMER_SKIP(TX_FRAMER_SKIP),
  .PATTERN_LOCK(PATTERN_LOCK));

// [sim/tbpc_top_tb.sv]
// Purpose: self-checking bench of the test pattern block
// Assumes: far side loops line and backplane streams back
// Notes:   generated stream checked by the recurrence of the selected pattern type
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tbpc_top_tb;
  logic        SYS_CLK = 1'b0;
  logic        NRST = 1'b0;
  logic [7:0]  AWADDR = 8'h00;
  logic [7:0]  ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0]  WSTRB = 4'hF;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0;
  logic        RREADY = 1'b0, flip = 1'b0, mute = 1'b0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TXB_DATA, TXB_VALID;
  logic        TXB_READY, LRX_DATA, LRX_VALID, LRX_READY, LTX_DATA, LTX_VALID;
  logic        LTX_READY, RXB_DATA, RXB_VALID, RXB_READY, PATTERN_LOCK;
  logic        RX_FRAMER_SKIP, TX_FRAMER_SKIP;
  logic [1:0]  BRESP, RRESP, be;
  logic [31:0] RDATA;
  logic [33:0] rq[$], re;
  logic [1:0]  bq[$];
  logic [19:0] h;
  logic [7:0]  ctl = 8'h00, ua;
  logic        wsw = 1'b0, winv = 1'b0, chk_on = 1'b0, b;
  int          n_errors = 0, n_tests = 0, cyc = 0, cnt = 0, errs = 0;
  tbpc_top u_tbpc_top (.*);
  tbpc_far u_far_line (.clk(SYS_CLK), .rst_n(NRST), .flip(flip), .mute(1'b0),
    .in_data(LTX_DATA), .in_valid(LTX_VALID), .in_ready(LTX_READY),
    .out_data(LRX_DATA), .out_valid(LRX_VALID), .out_ready(LRX_READY));
  tbpc_far u_far_bp (.clk(SYS_CLK), .rst_n(NRST), .flip(1'b0), .mute(mute),
    .in_data(RXB_DATA), .in_valid(RXB_VALID), .in_ready(RXB_READY),
    .out_data(TXB_DATA), .out_valid(TXB_VALID), .out_ready(TXB_READY));
  // 25 MHz
  always #20 SYS_CLK = ~SYS_CLK;
  task automatic wrap_up;
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard, far above the longest sequence
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // answers are paired with the oldest note; generated bits obey the recurrence
  always @(posedge SYS_CLK) begin
    if (RVALID && RREADY) begin
      re = rq.pop_front();
      `CHK("read", re, {RRESP, RDATA})
    end
    if (BVALID && BREADY) begin
      be = bq.pop_front();
      `CHK("bresp", be, BRESP)
    end
    if (chk_on && (wsw ? RXB_VALID && RXB_READY : LTX_VALID && LTX_READY)) begin
      b = wsw ? RXB_DATA : LTX_DATA;
      // longer history so the quasi-random recurrence is checked as well
      if (cnt >= 20 && (((ctl[tbpc_pkg::TYPE_BIT] ? h[19] ^ h[16] : h[14] ^ h[13]) ^ winv)
          !== b)) errs++;
      h = {h[18:0], b};
      cnt++;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    bq.push_back(r);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (aw && AWREADY) begin aw = 1'b0; AWVALID <= 1'b0; end
      if (w && WREADY) begin w = 1'b0; WVALID <= 1'b0; end
    end while (aw || w);
    do @(posedge SYS_CLK); while (!BVALID);
    BREADY <= 1'b0;
    // an edge passes so a following call does not re-raise the strobe in one step
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge SYS_CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge SYS_CLK); while (!RVALID);
    RREADY <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic cfg(input logic [7:0] c);
    ctl = c;
    winv = c[tbpc_pkg::INV_BIT];
    wr(tbpc_pkg::CTRL_OFS, {24'h0, c}, tbpc_pkg::RESP_OKAY);
  endtask
  task automatic swp(input logic s);
    wsw = s;
    wr(tbpc_pkg::SWAP_OFS, {31'h0, s}, tbpc_pkg::RESP_OKAY);
  endtask
  // let old bits flush before counting afresh
  task automatic restart(input int pre);
    repeat (pre) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    cnt = 0;
    errs = 0;
    // return on a rising edge so the next request starts there
    @(posedge SYS_CLK);
  endtask
  task automatic settle(input int n, input logic lk, input int ex);
    logic [7:0] v;
    repeat (n) @(posedge SYS_CLK);
    // look at the lock output away from the edge that updates it
    @(negedge SYS_CLK);
    `CHK("lock", lk, PATTERN_LOCK)
    @(posedge SYS_CLK);
    v = ctl & tbpc_pkg::CTRL_WMSK;
    v[tbpc_pkg::LOCK_BIT] = lk;
    rd(tbpc_pkg::CTRL_OFS, {2'h0, 24'h0, v});
    if (ex >= 0) `CHK("errors", ex, errs)
  endtask
  initial begin
    void'($urandom(32'h55171B49));
    repeat (10) @(posedge SYS_CLK);
    NRST <= 1'b1;
    rd(tbpc_pkg::CTRL_OFS, 34'h0);
    rd(tbpc_pkg::SWAP_OFS, 34'h0);
    for (int i = 0; i < 4; i++) begin
      cfg(8'(i));
      `CHK("rx skip", ctl[1], RX_FRAMER_SKIP)
      `CHK("tx skip", ctl[0], TX_FRAMER_SKIP)
    end
    ua = 8'h08 + 8'($urandom % 62) * 8'h04;
    wr(ua, 32'hFF, tbpc_pkg::RESP_SLVERR);
    rd(ua, {tbpc_pkg::RESP_SLVERR, 32'h0});
    chk_on = 1'b1;
    cfg(8'h0C);
    restart(40);
    settle(400, 1'b1, 0);
    // keep the bit count running so the flipped bit itself is checked
    errs = 0;
    cfg(8'h4C);
    settle(100, 1'b1, 3);
    mute <= 1'b1;
    cfg(8'h08);
    cfg(8'h48);
    restart(40);
    cfg(8'h4C);
    mute <= 1'b0;
    settle(400, 1'b1, 0);
    cfg(8'h2C);
    restart(40);
    settle(400, 1'b1, 0);
    cfg(8'h0C);
    swp(1'b1);
    restart(40);
    // refill the history first, else the flip lands in the unchecked start
    repeat (40) @(posedge SYS_CLK);
    cfg(8'h4C);
    settle(400, 1'b1, 3);
    cfg(8'h8C);
    restart(40);
    settle(400, 1'b1, 0);
    swp(1'b0);
    cfg(8'h8C);
    restart(40);
    settle(400, 1'b1, 0);
    chk_on = 1'b0;
    flip <= 1'b1;
    settle(200, 1'b0, -1);
    flip <= 1'b0;
    cfg(8'h04);
    settle(5, 1'b0, -1);
    NRST <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    NRST <= 1'b1;
    ctl = 8'h00;
    settle(2, 1'b0, -1);
    wrap_up();
  end
endmodule
